// *** sim/ocs_clock_select_asserts.sv ***
// Concurrent checks on the clock select top ports
`timescale 1ns/10ps
module ocs_clock_select_asserts (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] osc_mode_select,
	input wire logic osc_in_pin,
	input wire logic pwrt_en,
	input wire logic fscm_en,
	input wire logic wdt_en,
	input wire logic two_speed_en,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic dev_clk_tick,
	input wire logic osc_out_pin_o,
	input wire logic osc_out_pin_oe_n,
	input wire logic port_a_bit6_io,
	input wire logic port_a_bit7_io,
	input wire logic internal_slow_oscillator_on,
	input wire logic multiplier_on,
	input wire logic osc_startup_req
);
	logic [1:0] age_q;
	logic [1:0] ticks_q;
	logic seen_q;
	wire settled = age_q == 2'h3;
	wire slow_req = pwrt_en | fscm_en | wdt_en | two_speed_en;
	wire [3:0] m = osc_mode_select;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// ==========================================================
	// Edges since reset, ticks between clock-out changes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			age_q <= 2'h0;
			ticks_q <= 2'h0;
			seen_q <= 1'b0;
		end else begin
			if (!settled)
				age_q <= age_q + 2'h1;
			if ($changed(osc_out_pin_o)) begin
				seen_q <= 1'b1;
				ticks_q <= {1'b0, dev_clk_tick};
			end else if (dev_clk_tick && ticks_q != 2'h3)
				ticks_q <= ticks_q + 2'h1;
		end
	end

	// ==========================================================
	// Assertions
	sequence ext_edge_s;
		settled && m < 4'h8 && m != 4'h6 ##0 $rose(osc_in_pin);
	endsequence
	sequence slow_held_s;
		(settled && slow_req) [*3];
	endsequence

	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	pin6_free_a: assert property (
		settled |-> port_a_bit6_io == (m inside {4'h5, 4'h7, 4'h8}))
		else $error("port bit 6 release wrong");
	pin7_free_a: assert property (
		settled |-> port_a_bit7_io == (m inside {4'h8, 4'h9}))
		else $error("port bit 7 release wrong");
	out_drive_a: assert property (
		settled |-> osc_out_pin_oe_n == !(m inside {4'h3, 4'h4, 4'h9}))
		else $error("clock out drive enable wrong");
	startup_req_a: assert property (
		settled |-> osc_startup_req == (m inside {4'h0, 4'h1, 4'h2, 4'h6}))
		else $error("start-up request wrong");
	out_held_off_a: assert property (osc_out_pin_oe_n |-> !osc_out_pin_o)
		else $error("clock out active while released");
	slow_forced_a: assert property (slow_held_s |-> internal_slow_oscillator_on)
		else $error("slow oscillator not forced on");
	mul_source_a: assert property (multiplier_on |-> m inside {4'h6, 4'h8, 4'h9})
		else $error("multiplier on in wrong mode");
	tick_after_edge_a: assert property (ext_edge_s |-> ##[1:3] dev_clk_tick)
		else $error("no device tick after source edge");
	clkout_div4_a: assert property (
		settled && seen_q && $changed(osc_out_pin_o) |-> ticks_q == 2'h2)
		else $error("clock out not device clock over 4");
endmodule : ocs_clock_select_asserts

bind ocs_clock_select ocs_clock_select_asserts ocs_clock_select_asserts_inst (
	.sys_clk(sys_clk), .srst(srst), .osc_mode_select(osc_mode_select),
	.osc_in_pin(osc_in_pin), .pwrt_en(pwrt_en), .fscm_en(fscm_en), .wdt_en(wdt_en),
	.two_speed_en(two_speed_en), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.dev_clk_tick(dev_clk_tick), .osc_out_pin_o(osc_out_pin_o),
	.osc_out_pin_oe_n(osc_out_pin_oe_n), .port_a_bit6_io(port_a_bit6_io),
	.port_a_bit7_io(port_a_bit7_io), .multiplier_on(multiplier_on),
	.internal_slow_oscillator_on(internal_slow_oscillator_on),
	.osc_startup_req(osc_startup_req)
);

// *** sim/ocs_clock_select_test.sv ***
// Self-checking bench for the oscillator mode clock select
`timescale 1ns/10ps
module ocs_clock_select_test;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] mode = 4'h0;
	logic [3:0] en4 = 4'h0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic src_run = 1'b0;
	logic [3:0] half = 4'h2;
	logic osc_in_pin, dev_clk_tick, osc_out_pin_o, osc_out_pin_oe_n;
	logic port_a_bit6_io, port_a_bit7_io, fast_on, slow_on, multiplier_on, startup;
	logic [7:0] reg_rdata;
	logic [7:0] exp_q[$];
	logic [7:0] mask_q[$];
	logic [7:0] e8, m8;
	logic rd_pend = 1'b0;
	logic last_in = 1'b0;
	logic last_out = 1'b0;
	logic [31:0] rnd = 32'h5;
	int n_mismatch = 0;
	int cmp_count = 0;
	int nt, nr, ntg;

	always #5 sys_clk = !sys_clk;

	ocs_clock_select ocs_clock_select_inst (
		.sys_clk(sys_clk), .srst(srst), .osc_mode_select(mode), .osc_in_pin(osc_in_pin),
		.pwrt_en(en4[0]), .fscm_en(en4[1]), .wdt_en(en4[2]), .two_speed_en(en4[3]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dev_clk_tick(dev_clk_tick), .osc_out_pin_o(osc_out_pin_o),
		.osc_out_pin_oe_n(osc_out_pin_oe_n), .port_a_bit6_io(port_a_bit6_io),
		.port_a_bit7_io(port_a_bit7_io), .internal_fast_source_on(fast_on),
		.internal_slow_oscillator_on(slow_on), .multiplier_on(multiplier_on),
		.osc_startup_req(startup)
	);

	ocs_ext_src ocs_ext_src_inst (
		.sys_clk(sys_clk), .run(src_run), .half(half), .osc_in_pin(osc_in_pin)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic near(input string what, input int want, input int got, input int tol);
		chk(what, 16'(want), (got - want <= tol && want - got <= tol) ? 16'(want) : 16'(got));
	endtask : near

	task automatic final_report();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	// ==========================================================
	// Register port master, strobes held until the next task call
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : rd

	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle

	task automatic setmode(input logic [3:0] m);
		srst <= 1'b1;
		mode <= m;
		src_run <= 1'b0;
		en4 <= 4'h0;
		idle(10);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : setmode

	task automatic count(input int n);
		nt = 0;
		nr = 0;
		ntg = 0;
		last_in = osc_in_pin;
		last_out = osc_out_pin_o;
		repeat (n) begin
			@(posedge sys_clk);
			nt += int'(dev_clk_tick);
			nr += int'(osc_in_pin && !last_in);
			ntg += int'(osc_out_pin_o != last_out);
			last_in = osc_in_pin;
			last_out = osc_out_pin_o;
		end
	endtask : count

	// Read answers compared one cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_pend) begin
			e8 = exp_q.pop_front();
			m8 = mask_q.pop_front();
			chk("read data", {8'h00, e8 & m8}, {8'h00, reg_rdata & m8});
		end
		rd_pend <= reg_rd;
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		n_mismatch++;
		final_report();
	end

	// ==========================================================
	// Scenarios
	initial begin
		for (int m = 0; m < 10; m++) begin
			setmode(4'(m));
			chk("pin6 free", m inside {5, 7, 8}, port_a_bit6_io);
			chk("pin7 free", m inside {8, 9}, port_a_bit7_io);
			chk("out oe_n", !(m inside {3, 4, 9}), osc_out_pin_oe_n);
			chk("startup", m inside {0, 1, 2, 6}, startup);
			rd(2'h2, 8'(m), 8'h0f);
			wr(2'h1, 8'h40);
			rd(2'h1, 8'h00, 8'h40);
			rd(2'h3, 8'h00, 8'hff);
			idle(2);
			if (m < 8) begin
				rnd = xs(rnd);
				if (m == 1)
					half <= 4'hf;
				else if (m == 6)
					half <= 4'h5 + 4'(rnd % 9);
				else
					half <= 4'h2 + 4'(rnd % 12);
				src_run <= 1'b1;
				count(300);
				if (m == 6)
					near("x4 ticks", 4 * nr - 10, nt, 2);
				else
					near("ticks", nr, nt, 1);
				if (m == 3 || m == 4)
					near("clock out", nt, 2 * ntg, 2);
				chk("mul on", m == 6, multiplier_on);
			end
		end
		setmode(4'h9);
		rd(2'h0, 8'h40, 8'hff);
		rd(2'h1, 8'h00, 8'hff);
		for (int k = 15; k >= 0; k--) begin
			rnd = xs(rnd);
			wr(2'h0, {1'b0, 3'(k / 2), 4'h0});
			wr(2'h1, {1'(k % 2), 2'b10, rnd[4:0]});
			rd(2'h0, {1'b0, 3'(k / 2), 4'h0}, 8'hff);
			rd(2'h1, {1'(k % 2), 1'(k > 11), 1'b0, rnd[4:0]}, 8'hff);
			idle(3);
			chk("fast on", k > 0, fast_on);
			if (k == 0)
				chk("slow on", 1'b1, slow_on);
		end
		wr(2'h0, 8'h70);
		wr(2'h1, 8'h40);
		idle(200);
		count(200);
		chk("mul on", 1'b1, multiplier_on);
		near("mul rate", 64, nt, 3);
		near("clock out", nt, 2 * ntg, 2);
		rd(2'h2, 8'ha9, 8'hff);
		wr(2'h0, 8'h50);
		idle(2);
		rd(2'h1, 8'h00, 8'h40);
		idle(3);
		chk("mul on", 1'b0, multiplier_on);
		for (int i = 0; i < 4; i++) begin
			en4 <= 4'h1 << i;
			idle(4);
			chk("slow forced", 1'b1, slow_on);
		end
		idle(4);
		final_report();
	end
endmodule : ocs_clock_select_test

// *** sim/ocs_ext_src.sv ***
// External clock source model driving the oscillator input pin
`timescale 1ns/10ps
module ocs_ext_src (
	input wire logic sys_clk,
	input wire logic run,
	input wire logic [3:0] half,
	output logic osc_in_pin
);
	logic [3:0] cnt_q;

	// Toggles every half period while running, rests low when stopped
	always_ff @(posedge sys_clk) begin
		if (!run) begin
			cnt_q <= 4'h0;
			osc_in_pin <= 1'b0;
		end else if (cnt_q + 4'h1 >= half) begin
			cnt_q <= 4'h0;
			osc_in_pin <= !osc_in_pin;
		end else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule : ocs_ext_src

// *** verilog/ocs_clock_select.sv ***
// Oscillator mode clock select: primary modes, internal block, clock out
`timescale 1ns/10ps
`include "ocs_consts.svh"

module ocs_clock_select
	import ocs_pkg::*;
#(
	parameter int MUL_CNT_W = 8,
	parameter int PS_W = 8
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] osc_mode_select,
	input wire logic osc_in_pin,
	input wire logic pwrt_en,
	input wire logic fscm_en,
	input wire logic wdt_en,
	input wire logic two_speed_en,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic dev_clk_tick,
	output logic osc_out_pin_o,
	output logic osc_out_pin_oe_n,
	output logic port_a_bit6_io,
	output logic port_a_bit7_io,
	output logic internal_fast_source_on,
	output logic internal_slow_oscillator_on,
	output logic multiplier_on,
	output logic osc_startup_req
);

	initial begin
		if (PS_W < 8) begin
			$error("ocs_clock_select: PS_W must be at least 8");
		end
		if (MUL_CNT_W < 4) begin
			$error("ocs_clock_select: MUL_CNT_W must be at least 4");
		end
	end

	// ==========================================================
	// Functions
	// One step of a phase accumulator; top bit flags the tick
	function automatic logic [17:0] phase_step(input ocs_phase_t acc, input ocs_phase_t inc);
		logic [17:0] sum;
		sum = {1'b0, acc} + {1'b0, inc};
		if (sum >= {1'b0, `OCS_SYS_CLK_KHZ}) begin
			phase_step = {1'b1, 17'(sum - {1'b0, `OCS_SYS_CLK_KHZ})};
		end else begin
			phase_step = {1'b0, sum[16:0]};
		end
	endfunction : phase_step

	// Postscaler divide as a power of two
	function automatic logic [3:0] ps_shift(input logic [2:0] freq, input logic lf_fast);
		if (freq == `OCS_FREQ_31K) begin
			ps_shift = lf_fast ? `OCS_LF_DIV_SHIFT : 4'h0;
		end else begin
			ps_shift = 4'(3'h7 - freq);
		end
	endfunction : ps_shift

	// ==========================================================
	// Mode capture and decode
	ocs_mode_e mode_q;

	// Configuration field is sampled while reset is held
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_q <= ocs_mode_e'(osc_mode_select);
		end
	end

	wire logic mode_int_w = (mode_q == OCS_MODE_INTERNAL_OSC_CLKOUT) ||
		(mode_q == OCS_MODE_INTERNAL_OSC_TWO_GPIO);
	wire logic mode_x4_w = (mode_q == OCS_MODE_FAST_CRYSTAL_X4);
	wire logic mode_ext_w = (mode_q == OCS_MODE_EXT_CLK_OUT) ||
		(mode_q == OCS_MODE_EXT_CLK_PIN_FREE);
	wire logic mode_xtal_w = (mode_q == OCS_MODE_SLOW_CRYSTAL) ||
		(mode_q == OCS_MODE_MEDIUM_CRYSTAL) || (mode_q == OCS_MODE_FAST_CRYSTAL) ||
		mode_x4_w;
	// Clock-out on osc out pin
	wire logic clkout_mode_w = (mode_q == OCS_MODE_EXT_CLK_OUT) ||
		(mode_q == OCS_MODE_RESISTOR_CAP_OSC) ||
		(mode_q == OCS_MODE_INTERNAL_OSC_CLKOUT);
	wire logic bit6_gpio_w = (mode_q == OCS_MODE_EXT_CLK_PIN_FREE) ||
		(mode_q == OCS_MODE_RESISTOR_CAP_PIN_FREE) ||
		(mode_q == OCS_MODE_INTERNAL_OSC_TWO_GPIO);
	wire logic bit7_gpio_w = mode_int_w;

	// ==========================================================
	// Registers
	logic [2:0] freq_sel_q;
	logic lf_src_q;
	logic mul_en_q;
	logic [4:0] trim_q;
	ocs_byte_t rdata_q;
	logic fast_on_q;
	logic slow_on_q;

	wire logic wr_ctrl_w = reg_wr && (reg_addr == `OCS_IDX_CTRL);
	wire logic wr_tune_w = reg_wr && (reg_addr == `OCS_IDX_TUNE);
	wire logic [2:0] freq_next_w = wr_ctrl_w ?
		reg_wdata[`OCS_CTRL_FREQ_MSB:`OCS_CTRL_FREQ_LSB] : freq_sel_q;
	// Multiplier allowed only for internal modes at 4 or 8 MHz
	wire logic mul_allow_w = mode_int_w &&
		((freq_next_w == `OCS_FREQ_8M) || (freq_next_w == `OCS_FREQ_4M));

	wire logic mul_act_w = mode_x4_w || (mode_int_w && mul_en_q);

	wire ocs_byte_t ctrl_rd_w = {1'b0, freq_sel_q, 4'h0};
	wire ocs_byte_t tune_rd_w = {lf_src_q, mul_en_q, 1'b0, trim_q};
	wire ocs_byte_t stat_rd_w = {fast_on_q, slow_on_q, mul_act_w, 1'b0, mode_q};
	wire ocs_byte_t rd_mux_w = (reg_addr == `OCS_IDX_CTRL) ? ctrl_rd_w :
		(reg_addr == `OCS_IDX_TUNE) ? tune_rd_w :
		(reg_addr == `OCS_IDX_STAT) ? stat_rd_w : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			freq_sel_q <= 3'(`OCS_CTRL_RST >> `OCS_CTRL_FREQ_LSB);
		end else if (wr_ctrl_w) begin
			freq_sel_q <= freq_next_w;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lf_src_q <= 1'(`OCS_TUNE_RST >> `OCS_TUNE_LFSRC_BIT);
			trim_q <= 5'(`OCS_TUNE_RST);
		end else if (wr_tune_w) begin
			lf_src_q <= reg_wdata[`OCS_TUNE_LFSRC_BIT];
			trim_q <= reg_wdata[`OCS_TUNE_TRIM_MSB:0];
		end
	end

	// Enable bit cleared and write ignored while not allowed
	always_ff @(posedge sys_clk) begin
		if (srst || !mul_allow_w) begin
			mul_en_q <= 1'b0;
		end else if (wr_tune_w) begin
			mul_en_q <= reg_wdata[`OCS_TUNE_MULEN_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_rd ? rd_mux_w : 8'h00;
		end
	end

	// ==========================================================
	// Internal fast source and slow oscillator
	ocs_phase_t fast_acc_q;
	ocs_phase_t slow_acc_q;
	logic [PS_W-1:0] ps_cnt_q;

	wire logic lf_sel_w = (freq_sel_q == `OCS_FREQ_31K);
	wire logic fast_need_w = mode_int_w && (!lf_sel_w || lf_src_q);
	wire logic slow_sel_w = mode_int_w && lf_sel_w && !lf_src_q;
	wire logic slow_need_w = slow_sel_w ||
		pwrt_en || fscm_en || wdt_en || two_speed_en;
	wire logic [17:0] fast_step_w = phase_step(fast_acc_q, `OCS_FAST_SRC_KHZ);
	wire logic [17:0] slow_step_w = phase_step(slow_acc_q, `OCS_SLOW_OSC_KHZ);
	wire logic fast_tick_w = fast_on_q && fast_step_w[17];
	wire logic slow_tick_w = slow_on_q && slow_step_w[17];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fast_on_q <= 1'b0;
			slow_on_q <= 1'b0;
		end else begin
			fast_on_q <= fast_need_w;
			slow_on_q <= slow_need_w;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || !fast_on_q) begin
			fast_acc_q <= '0;
		end else begin
			fast_acc_q <= fast_step_w[16:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || !slow_on_q) begin
			slow_acc_q <= '0;
		end else begin
			slow_acc_q <= slow_step_w[16:0];
		end
	end

	// ==========================================================
	// Postscaler and internal selection
	wire logic [3:0] ps_sh_w = ps_shift(freq_sel_q, lf_src_q);
	wire logic [PS_W-1:0] ps_mask_w = PS_W'((9'h001 << ps_sh_w) - 9'h001);
	wire logic ps_tick_w = fast_tick_w && ((ps_cnt_q & ps_mask_w) == ps_mask_w);

	always_ff @(posedge sys_clk) begin
		if (srst || !fast_on_q) begin
			ps_cnt_q <= '0;
		end else if (fast_tick_w) begin
			ps_cnt_q <= ps_cnt_q + PS_W'(1);
		end
	end

	// Fast direct at 8 MHz, slow direct or postscaled otherwise
	wire logic int_tick_w = slow_sel_w ? slow_tick_w :
		(freq_sel_q == `OCS_FREQ_8M) ? fast_tick_w : ps_tick_w;

	// ==========================================================
	// External input edges
	logic osc_in_prev_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			osc_in_prev_q <= 1'b0;
		end else begin
			osc_in_prev_q <= osc_in_pin;
		end
	end

	// Crystal, RC and external clock all arrive here
	wire logic ext_tick_w = osc_in_pin && !osc_in_prev_q && !mode_int_w;

	// ==========================================================
	// Times-4 multiplier
	ocs_mul_if mul_if ();

	assign mul_if.enable = mul_act_w;
	assign mul_if.ref_tick = mode_x4_w ? ext_tick_w : int_tick_w;

	ocs_mul4 #(
		.CNT_W(MUL_CNT_W)
	) u_mul4 (
		.clk(sys_clk),
		.srst(srst),
		.link(mul_if.mul)
	);

	// ==========================================================
	// Device clock tick
	wire logic dev_tick_w = mul_act_w ? mul_if.out_tick :
		mode_int_w ? int_tick_w : ext_tick_w;
	logic dev_tick_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dev_tick_q <= 1'b0;
		end else begin
			dev_tick_q <= dev_tick_w;
		end
	end

	// ==========================================================
	// Divide-by-4 clock out and pin ownership
	logic clkout_q;
	logic clkout_ph_q;
	logic out_oe_n_q;
	logic bit6_q;
	logic bit7_q;

	// Phase restarts whenever the pin is not a clock out
	always_ff @(posedge sys_clk) begin
		if (srst || !clkout_mode_w) begin
			clkout_ph_q <= 1'b0;
			clkout_q <= 1'b0;
		end else if (dev_tick_w) begin
			clkout_ph_q <= !clkout_ph_q;
			if (clkout_ph_q) begin
				clkout_q <= !clkout_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			out_oe_n_q <= 1'b1;
			bit6_q <= 1'b0;
			bit7_q <= 1'b0;
		end else begin
			out_oe_n_q <= !clkout_mode_w;
			bit6_q <= bit6_gpio_w;
			bit7_q <= bit7_gpio_w;
		end
	end

	// ==========================================================
	// Status outputs
	logic mul_on_q;
	logic startup_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mul_on_q <= 1'b0;
			startup_q <= 1'b0;
		end else begin
			mul_on_q <= mul_act_w && mul_if.locked;
			startup_q <= mode_xtal_w && !mode_ext_w;
		end
	end

	assign reg_rdata = rdata_q;
	assign dev_clk_tick = dev_tick_q;
	assign osc_out_pin_o = clkout_q;
	assign osc_out_pin_oe_n = out_oe_n_q;
	assign port_a_bit6_io = bit6_q;
	assign port_a_bit7_io = bit7_q;
	assign internal_fast_source_on = fast_on_q;
	assign internal_slow_oscillator_on = slow_on_q;
	assign multiplier_on = mul_on_q;
	assign osc_startup_req = startup_q;

endmodule : ocs_clock_select

// *** verilog/ocs_consts.svh ***
// Constants for the oscillator mode clock select block
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH

// ==========================================================
// Register indices on the plain register port
`define OCS_IDX_CTRL 2'h0
`define OCS_IDX_TUNE 2'h1
`define OCS_IDX_STAT 2'h2

// ==========================================================
// Field positions
`define OCS_CTRL_FREQ_LSB 4
`define OCS_CTRL_FREQ_MSB 6
`define OCS_TUNE_LFSRC_BIT 7
`define OCS_TUNE_MULEN_BIT 6
`define OCS_TUNE_TRIM_MSB 4

// ==========================================================
// Reset values
`define OCS_CTRL_RST 8'h40
`define OCS_TUNE_RST 8'h00

// ==========================================================
// Frequency select codes
`define OCS_FREQ_8M 3'h7
`define OCS_FREQ_4M 3'h6
`define OCS_FREQ_31K 3'h0

// ==========================================================
// Rates in kHz; sources are phase accumulators at the system clock
`define OCS_SYS_CLK_KHZ 17'd100000
`define OCS_FAST_SRC_KHZ 17'd8000
`define OCS_SLOW_OSC_KHZ 17'd31
`define OCS_LF_DIV_SHIFT 4'h8
`define OCS_MUL_FACTOR 2'h3

`endif

// *** verilog/ocs_mul4.sv ***
// Times-4 tick multiplier: four evenly spaced ticks per reference period
`timescale 1ns/10ps
module ocs_mul4
	import ocs_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic srst,
	ocs_mul_if.mul link
);

	initial begin
		if (CNT_W < 4) begin
			$error("ocs_mul4: CNT_W must be at least 4");
		end
	end

	ocs_mul_state_e state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] quarter_q;
	logic [CNT_W-1:0] phase_q;
	logic [1:0] left_q;
	logic out_tick_q;

	// ==========================================================
	// Quarter period, never below one cycle
	wire logic [CNT_W-1:0] quarter_w = (cnt_q[CNT_W-1:2] == '0) ? CNT_W'(1) :
		CNT_W'(cnt_q >> 2);
	wire logic cnt_max_w = (cnt_q == '1);
	wire logic fill_w = (state_q == OCS_MUL_RUN) && !link.ref_tick &&
		(left_q != 2'h0) && (phase_q == CNT_W'(1));

	always_ff @(posedge clk) begin
		if (srst || !link.enable) begin
			state_q <= OCS_MUL_IDLE;
		end else begin
			unique case (state_q)
				OCS_MUL_IDLE: state_q <= OCS_MUL_ACQ;
				OCS_MUL_ACQ: if (link.ref_tick) state_q <= OCS_MUL_MEAS;
				OCS_MUL_MEAS: if (link.ref_tick) state_q <= OCS_MUL_RUN;
				OCS_MUL_RUN: state_q <= OCS_MUL_RUN;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst || link.ref_tick) begin
			cnt_q <= CNT_W'(1);
		end else if (!cnt_max_w) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// Reference edge in run emits the first tick and rearms three more
	always_ff @(posedge clk) begin
		if (srst || state_q == OCS_MUL_IDLE) begin
			quarter_q <= CNT_W'(1);
			phase_q <= CNT_W'(1);
			left_q <= 2'h0;
			out_tick_q <= 1'b0;
		end else if (link.ref_tick && state_q != OCS_MUL_ACQ) begin
			quarter_q <= quarter_w;
			phase_q <= quarter_w;
			left_q <= (state_q == OCS_MUL_RUN) ? `OCS_MUL_FACTOR : 2'h0;
			out_tick_q <= (state_q == OCS_MUL_RUN);
		end else if (fill_w) begin
			phase_q <= quarter_q;
			left_q <= left_q - 2'h1;
			out_tick_q <= 1'b1;
		end else begin
			if (phase_q != CNT_W'(1)) begin
				phase_q <= phase_q - CNT_W'(1);
			end
			out_tick_q <= 1'b0;
		end
	end

	assign link.out_tick = out_tick_q;
	assign link.locked = (state_q == OCS_MUL_RUN);

endmodule : ocs_mul4

// *** verilog/ocs_mul_if.sv ***
// Link between the clock select and its times-4 multiplier
`timescale 1ns/10ps
interface ocs_mul_if;
	logic enable;
	logic ref_tick;
	logic out_tick;
	logic locked;

	modport ctrl (
		output enable,
		output ref_tick,
		input out_tick,
		input locked
	);

	modport mul (
		input enable,
		input ref_tick,
		output out_tick,
		output locked
	);
endinterface : ocs_mul_if

// *** verilog/ocs_pkg.sv ***
// Types for the oscillator mode clock select block
package ocs_pkg;

	// ==========================================================
	// Primary oscillator modes
	typedef enum logic [3:0] {
		OCS_MODE_SLOW_CRYSTAL = 4'h0,
		OCS_MODE_MEDIUM_CRYSTAL = 4'h1,
		OCS_MODE_FAST_CRYSTAL = 4'h2,
		OCS_MODE_RESISTOR_CAP_OSC = 4'h3,
		OCS_MODE_EXT_CLK_OUT = 4'h4,
		OCS_MODE_EXT_CLK_PIN_FREE = 4'h5,
		OCS_MODE_FAST_CRYSTAL_X4 = 4'h6,
		OCS_MODE_RESISTOR_CAP_PIN_FREE = 4'h7,
		OCS_MODE_INTERNAL_OSC_TWO_GPIO = 4'h8,
		OCS_MODE_INTERNAL_OSC_CLKOUT = 4'h9
	} ocs_mode_e;

	// ==========================================================
	// Multiplier states, Gray along the path
	typedef enum logic [1:0] {
		OCS_MUL_IDLE = 2'h0,
		OCS_MUL_ACQ = 2'h1,
		OCS_MUL_MEAS = 2'h3,
		OCS_MUL_RUN = 2'h2
	} ocs_mul_state_e;

	typedef logic [7:0] ocs_byte_t;
	typedef logic [16:0] ocs_phase_t;

endpackage : ocs_pkg
